// >>> scc_pkg.sv
// constants and types for the system control and clock select block
// ****************************************************************
// How it works
// [RULE1] edge field: 00 off, 01 rising, 10 falling, 11 both edges
// [RULE2] time base period is 2^10..2^13 timer base clocks by code
// [RULE3] watchdog off only for code 1010, any other code enables it
// [RULE4] always-on option forces watchdog on, ignoring the code
// [RULE5] any PWM pin selected forces timer base clock from system clock
// [RULE6] DAC enable at bit 7 of second register, resets to zero
// [RULE7] bits 5 and 4 route PWM3 and PWM2 to their pins when set
// [RULE8] bit 0 keeps slow crystal running after halt, resets to one
// [RULE9] slow crystal stays a clock for watchdog, time base, timers in halt
// [RULE10] halt always stops the system clock
// [RULE11] source select high makes slow crystal the system clock
// [RULE12] slow crystal usable only when its option enables it
// [RULE13] watchdog RC oscillator never becomes the system clock
// [RULE14] system clock from one of three fast sources or slow crystal
// [RULE15] internal fast RC offers 4, 8 or 12 MHz
// [RULE16] internal fast RC frees port A lines 5 and 6
// [RULE17] external RC takes only line 6, line 5 stays general I/O
// [RULE18] unimplemented bits 6 and 3..1 of second register read zero
// [RULE19] low-power bit clears at reset, selects quick start
// [RULE20] mode: normal, slow, idle or sleep from halt, select and keep bits
// [RULE21] writes act from next edge, every field resets to power-on value
// ****************************************************************
package scc_pkg;
  localparam logic [31:0] SCC_ADDR_ITW = 32'h0000_0000;
  localparam logic [31:0] SCC_ADDR_DPS = 32'h0000_0004;
  localparam logic [31:0] SCC_ADDR_MISC = 32'h0000_0008;
  localparam logic [31:0] SCC_ADDR_STAT = 32'h0000_000c;
  localparam logic [7:0] SCC_ITW_RST = 8'h8a;
  localparam logic [7:0] SCC_DPS_RST = 8'h01;
  localparam logic [1:0] SCC_MISC_RST = 2'h0;
  localparam logic [7:0] SCC_DPS_MASK = 8'hb1;
  localparam logic [3:0] SCC_WDT_OFF_CODE = 4'ha;
  localparam int SCC_EDGE_HI = 7;
  localparam int SCC_TB_HI = 5;
  localparam int SCC_WDT_HI = 3;
  localparam int SCC_DAC_BIT = 7;
  localparam int SCC_PWM3_BIT = 5;
  localparam int SCC_PWM2_BIT = 4;
  localparam int SCC_KEEP_BIT = 0;
  localparam int SCC_LP_BIT = 1;
  localparam int SCC_SEL_BIT = 0;
  localparam int SCC_TB_BASE_LOG = 10;
  localparam logic [1:0] SCC_RESP_OKAY = 2'h0;
  localparam logic [1:0] SCC_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    SCC_MODE_NORMAL = 2'b00,
    SCC_MODE_SLOW = 2'b01,
    SCC_MODE_IDLE = 2'b10,
    SCC_MODE_SLEEP = 2'b11
  } scc_mode_e;
  typedef enum logic [1:0] {
    SCC_FAST_XTAL = 2'b00,
    SCC_FAST_ERC = 2'b01,
    SCC_FAST_IRC = 2'b10
  } scc_fast_e;
  typedef enum logic [1:0] {
    SCC_ST_IDLE = 2'b00,
    SCC_ST_RESP = 2'b01
  } scc_bus_e;
endpackage

// >>> scc_top.sv
// three control registers, status register and clock select logic of the system control block
`timescale 1ns/1ps
module scc_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // configuration options and core state
  input wire logic opt_wdt_always_on,
  input wire logic opt_slow_osc_enable,
  input wire logic [1:0] opt_fast_source,
  input wire logic [1:0] opt_fast_rc_freq,
  input wire logic halt_active,
  // decoded controls
  output logic [1:0] ext_int_edge_sel,
  output logic ext_int_enable,
  output logic ext_int_rising,
  output logic ext_int_falling,
  output logic [13:0] timebase_period_m1,
  output logic wdt_enable,
  output logic dac_enable,
  output logic pwm3_pin_select,
  output logic pwm2_pin_select,
  output logic timer_base_from_sys,
  output logic slow_osc_run,
  output logic slow_osc_low_power,
  output logic sys_clk_run,
  output logic sys_clk_from_slow,
  output logic fast_osc_run,
  output logic [1:0] fast_source,
  output logic [1:0] fast_rc_freq,
  output logic port_a_line5_gpio,
  output logic port_a_line6_gpio,
  output scc_pkg::scc_mode_e op_mode
);
  import scc_pkg::*;

  // ****************************************************************
  // register file
  // ****************************************************************
  logic [7:0] itw_q;
  logic [7:0] dps_q;
  logic [1:0] misc_q;
  logic aw_held_q;
  logic w_held_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  scc_bus_e wr_st_q;
  logic do_write;

  function automatic logic [31:0] word_align(input logic [31:0] a);
    word_align = {a[31:2], 2'b00};
  endfunction

  function automatic logic hit(input logic [31:0] a);
    hit = (word_align(a) == SCC_ADDR_ITW) || (word_align(a) == SCC_ADDR_DPS) ||
          (word_align(a) == SCC_ADDR_MISC) || (word_align(a) == SCC_ADDR_STAT);
  endfunction

  assign do_write = (wr_st_q == SCC_ST_IDLE) && aw_held_q && w_held_q;

  // address and data taken in either order, then one response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 32'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= SCC_RESP_OKAY;
      wr_st_q <= SCC_ST_IDLE;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      case (wr_st_q)
        SCC_ST_IDLE: begin
          if (s_axi_awvalid && !aw_held_q && !s_axi_awready) begin
            s_axi_awready <= 1'b1;
            aw_held_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
          end
          if (s_axi_wvalid && !w_held_q && !s_axi_wready) begin
            s_axi_wready <= 1'b1;
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
          end
          if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= hit(awaddr_q) ? SCC_RESP_OKAY : SCC_RESP_SLVERR;
            wr_st_q <= SCC_ST_RESP;
          end
        end
        SCC_ST_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            wr_st_q <= SCC_ST_IDLE;
          end
        end
        default: wr_st_q <= SCC_ST_IDLE;
      endcase
    end
  end

  // control registers, byte lane 0 only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      itw_q <= SCC_ITW_RST; // RULE21
      dps_q <= SCC_DPS_RST; // RULE8
      misc_q <= SCC_MISC_RST; // RULE19
    end else if (do_write && wstrb_q[0]) begin
      if (word_align(awaddr_q) == SCC_ADDR_ITW) begin
        itw_q <= wdata_q[7:0];
      end
      if (word_align(awaddr_q) == SCC_ADDR_DPS) begin
        dps_q <= wdata_q[7:0] & SCC_DPS_MASK; // RULE18
      end
      if (word_align(awaddr_q) == SCC_ADDR_MISC) begin
        misc_q <= wdata_q[1:0];
      end
    end
  end

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= SCC_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else if (s_axi_arvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= hit(s_axi_araddr) ? SCC_RESP_OKAY : SCC_RESP_SLVERR;
        case (word_align(s_axi_araddr))
          SCC_ADDR_ITW: s_axi_rdata <= {24'h0, itw_q};
          SCC_ADDR_DPS: s_axi_rdata <= {24'h0, dps_q & SCC_DPS_MASK}; // RULE18
          SCC_ADDR_MISC: s_axi_rdata <= {30'h0, misc_q};
          SCC_ADDR_STAT: s_axi_rdata <= {28'h0, wdt_enable, sys_clk_run, op_mode};
          default: s_axi_rdata <= 32'h0;
        endcase
      end
    end
  end

  // ****************************************************************
  // decoded controls
  // ****************************************************************
  logic slow_ok;
  logic sel_slow;
  logic keep;
  logic any_pwm;
  assign slow_ok = opt_slow_osc_enable; // RULE12
  assign sel_slow = misc_q[SCC_SEL_BIT] & slow_ok;
  assign keep = dps_q[SCC_KEEP_BIT] & slow_ok;
  assign any_pwm = dps_q[SCC_PWM3_BIT] | dps_q[SCC_PWM2_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_int_edge_sel <= SCC_ITW_RST[SCC_EDGE_HI -: 2];
      ext_int_enable <= 1'b0;
      ext_int_rising <= 1'b0;
      ext_int_falling <= 1'b0;
      timebase_period_m1 <= 14'h03ff;
    end else begin
      ext_int_edge_sel <= itw_q[SCC_EDGE_HI -: 2]; // RULE1
      ext_int_enable <= itw_q[SCC_EDGE_HI -: 2] != 2'b00; // RULE1
      ext_int_rising <= itw_q[SCC_EDGE_HI - 1]; // RULE1
      ext_int_falling <= itw_q[SCC_EDGE_HI]; // RULE1
      timebase_period_m1 <= 14'((32'd1 << (SCC_TB_BASE_LOG + itw_q[SCC_TB_HI -: 2])) - 32'd1); // RULE2
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_enable <= 1'b0;
      dac_enable <= 1'b0;
      pwm3_pin_select <= 1'b0;
      pwm2_pin_select <= 1'b0;
      timer_base_from_sys <= 1'b0;
      slow_osc_low_power <= 1'b0;
    end else begin
      wdt_enable <= opt_wdt_always_on || (itw_q[SCC_WDT_HI:0] != SCC_WDT_OFF_CODE); // RULE3 RULE4
      dac_enable <= dps_q[SCC_DAC_BIT]; // RULE6
      pwm3_pin_select <= dps_q[SCC_PWM3_BIT]; // RULE7
      pwm2_pin_select <= dps_q[SCC_PWM2_BIT]; // RULE7
      timer_base_from_sys <= any_pwm; // RULE5
      slow_osc_low_power <= misc_q[SCC_LP_BIT]; // RULE19
    end
  end

  // clock routing and operating mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slow_osc_run <= 1'b0;
      sys_clk_run <= 1'b0;
      sys_clk_from_slow <= 1'b0;
      fast_osc_run <= 1'b0;
      fast_source <= SCC_FAST_XTAL;
      fast_rc_freq <= 2'h0;
      port_a_line5_gpio <= 1'b0;
      port_a_line6_gpio <= 1'b0;
      op_mode <= SCC_MODE_NORMAL;
    end else begin
      slow_osc_run <= slow_ok && (!halt_active || keep); // RULE9 RULE12
      sys_clk_run <= !halt_active; // RULE10
      sys_clk_from_slow <= sel_slow; // RULE11 RULE13
      fast_osc_run <= !halt_active && !sel_slow; // RULE14
      fast_source <= opt_fast_source; // RULE14
      fast_rc_freq <= (opt_fast_rc_freq == 2'h3) ? 2'h0 : opt_fast_rc_freq; // RULE15
      port_a_line5_gpio <= opt_fast_source != SCC_FAST_XTAL; // RULE16 RULE17
      port_a_line6_gpio <= opt_fast_source == SCC_FAST_IRC; // RULE16 RULE17
      if (!halt_active) begin
        op_mode <= sel_slow ? SCC_MODE_SLOW : SCC_MODE_NORMAL; // RULE20
      end else begin
        op_mode <= keep ? SCC_MODE_IDLE : SCC_MODE_SLEEP; // RULE20
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_EDGE_DISABLE: assert property (itw_q[7:6] == 2'b00 |=> !ext_int_enable) // RULE1
    else $error("edge code 00 did not disable interrupt");
  AST_EDGE_RISE: assert property ( // RULE1
    itw_q[7:6] == 2'b01 |=> ext_int_rising && !ext_int_falling && ext_int_enable)
    else $error("edge code 01 not rising only");
  AST_EDGE_FALL: assert property ( // RULE1
    itw_q[7:6] == 2'b10 |=> !ext_int_rising && ext_int_falling && ext_int_enable)
    else $error("edge code 10 not falling only");
  AST_EDGE_BOTH: assert property ( // RULE1
    itw_q[7:6] == 2'b11 |=> ext_int_rising && ext_int_falling && ext_int_enable)
    else $error("edge code 11 not both edges");
  AST_TB_PERIOD: assert property (itw_q[5:4] == 2'b11 |=> timebase_period_m1 == 14'h1fff) // RULE2
    else $error("time base period wrong for code 11");
  AST_TB_SHORT: assert property ( // RULE2
    itw_q[5:4] == 2'b00 |=> timebase_period_m1 == 14'h03ff)
    else $error("time base period wrong for code 00");
  AST_TB_MID: assert property ( // RULE2
    itw_q[5:4] == 2'b01 |=> timebase_period_m1 == 14'h07ff)
    else $error("time base period wrong for code 01");
  AST_WDT_OFF: assert property (!opt_wdt_always_on && itw_q[3:0] == 4'ha |=> !wdt_enable) // RULE3
    else $error("watchdog not off for code 1010");
  AST_WDT_ON: assert property ( // RULE3
    itw_q[3:0] != 4'ha |=> wdt_enable)
    else $error("watchdog off for an enabling code");
  AST_WDT_FORCE: assert property (opt_wdt_always_on |=> wdt_enable) // RULE4
    else $error("always-on option ignored");
  AST_PWM_TBASE: assert property ((dps_q[5] || dps_q[4]) |=> timer_base_from_sys) // RULE5
    else $error("pwm selected but timer base not from system clock");
  AST_DAC: assert property ($rose(dps_q[7]) |=> dac_enable) // RULE6
    else $error("dac enable did not follow register");
  AST_DAC_OFF: assert property ( // RULE6
    !dps_q[7] |=> !dac_enable)
    else $error("dac enabled with bit clear");
  AST_PWM_PIN: assert property (dps_q[5] |=> pwm3_pin_select) // RULE7
    else $error("pwm3 pin select did not follow");
  AST_PWM2_PIN: assert property ( // RULE7
    dps_q[4] |=> pwm2_pin_select)
    else $error("pwm2 pin select did not follow");
  AST_SLOW_HALT: assert property (halt_active && dps_q[0] && opt_slow_osc_enable |=> slow_osc_run) // RULE9
    else $error("slow crystal stopped in idle");
  AST_HALT_STOP: assert property (halt_active |=> !sys_clk_run ##0 op_mode inside {SCC_MODE_IDLE, SCC_MODE_SLEEP}) // RULE10
    else $error("system clock ran during halt");
  AST_CLK_RUN: assert property ( // RULE10
    !halt_active |=> sys_clk_run)
    else $error("system clock stopped without halt");
  AST_SLOW_SEL: assert property ( // RULE11
    opt_slow_osc_enable && misc_q[0] |=> sys_clk_from_slow)
    else $error("slow crystal not system clock when selected");
  AST_NO_SLOW: assert property ( // RULE12
    !opt_slow_osc_enable |=> !slow_osc_run && !sys_clk_from_slow)
    else $error("slow crystal used while option off");
  AST_FAST_STOP: assert property ( // RULE14
    halt_active || sel_slow |=> !fast_osc_run)
    else $error("fast oscillator ran in slow or halt");
  AST_RC_FREQ: assert property ( // RULE15
    opt_fast_rc_freq != 2'h3 |=> fast_rc_freq == $past(opt_fast_rc_freq))
    else $error("fast rc frequency not passed on");
  AST_IRC_FREE: assert property ( // RULE16
    opt_fast_source == SCC_FAST_IRC |=> port_a_line5_gpio && port_a_line6_gpio)
    else $error("internal rc did not free both lines");
  AST_ERC_PIN: assert property ( // RULE17
    opt_fast_source == SCC_FAST_ERC |=> port_a_line5_gpio && !port_a_line6_gpio)
    else $error("external rc pin use wrong");
  AST_RSV_ZERO: assert property (s_axi_rvalid && $rose(s_axi_rvalid) && $past(word_align(s_axi_araddr)) == SCC_ADDR_DPS
                                 |-> s_axi_rdata[6] == 1'b0 && s_axi_rdata[3:1] == 3'h0) // RULE18
    else $error("reserved bits read nonzero");
  AST_LP: assert property ( // RULE19
    misc_q[1] |=> slow_osc_low_power)
    else $error("low power bit did not follow");
  AST_MODE_SLOW: assert property (!halt_active && sel_slow |=> op_mode == SCC_MODE_SLOW) // RULE20
    else $error("mode not slow");
  AST_MODE_NORMAL: assert property ( // RULE20
    !halt_active && !sel_slow |=> op_mode == SCC_MODE_NORMAL)
    else $error("mode not normal");
  AST_MODE_IDLE: assert property ( // RULE20
    halt_active && keep |=> op_mode == SCC_MODE_IDLE)
    else $error("mode not idle");
  AST_MODE_SLEEP: assert property ( // RULE20
    halt_active && !keep |=> op_mode == SCC_MODE_SLEEP)
    else $error("mode not sleep");
  AST_WR_NEXT: assert property (do_write && wstrb_q[0] && word_align(awaddr_q) == SCC_ADDR_ITW
                                |=> itw_q == $past(wdata_q[7:0])) // RULE21
    else $error("write did not land next edge");

  COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
  COV_READ: cover property (s_axi_rvalid && s_axi_rready);
  COV_IDLE: cover property (op_mode == SCC_MODE_IDLE);
  COV_WDT_OFF: cover property (!wdt_enable);
  COV_SLOW: cover property (op_mode == SCC_MODE_SLOW);
endmodule

// >>> tb_top.sv
// self-checking bench for the system control and clock select block
`timescale 1ns/1ps
module tb_top;
  import scc_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, opt_fast_source, opt_fast_rc_freq;
  logic opt_wdt_always_on, opt_slow_osc_enable, halt_active;
  logic [1:0] ext_int_edge_sel, fast_source, fast_rc_freq;
  logic ext_int_enable, ext_int_rising, ext_int_falling, wdt_enable, dac_enable;
  logic pwm3_pin_select, pwm2_pin_select, timer_base_from_sys, slow_osc_run, slow_osc_low_power;
  logic sys_clk_run, sys_clk_from_slow, fast_osc_run, port_a_line5_gpio, port_a_line6_gpio;
  logic [13:0] timebase_period_m1;
  scc_mode_e op_mode;
  int n_mismatch, cmp_count;
  logic [31:0] seed, rd_q;
  logic [1:0] rsp;
  logic [7:0] c1 [4] = '{8'h0a, 8'h5a, 8'hff, 8'h05};

  scc_top i_scc_top (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .opt_wdt_always_on, .opt_slow_osc_enable, .opt_fast_source, .opt_fast_rc_freq, .halt_active,
    .ext_int_edge_sel, .ext_int_enable, .ext_int_rising, .ext_int_falling, .timebase_period_m1,
    .wdt_enable, .dac_enable, .pwm3_pin_select, .pwm2_pin_select, .timer_base_from_sys,
    .slow_osc_run, .slow_osc_low_power, .sys_clk_run, .sys_clk_from_slow, .fast_osc_run,
    .fast_source, .fast_rc_freq, .port_a_line5_gpio, .port_a_line6_gpio, .op_mode
  );

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
  endfunction

  task automatic close_out;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rsp(input string nm, input logic [1:0] e, input logic [1:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // bounded wait: a hang ends the run as a mismatch
  task automatic tick(inout int n);
    n++;
    if (n > 50) begin
      n_mismatch++;
      close_out();
    end
  endtask

  task automatic settle;
    repeat (2) @(posedge aclk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [3:0] st);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (1) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
      tick(n);
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (1) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
      tick(n);
    end
    rd_q = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic chk_por;
    rd(SCC_ADDR_ITW);
    chk("itw reset", 32'h8a, rd_q);
    rd(SCC_ADDR_DPS);
    chk("dps reset", 32'h01, rd_q);
    rd(SCC_ADDR_MISC);
    chk("misc reset", 32'h0, rd_q);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [7:0] v;
    logic [1:0] m;
    logic h, en, sl, kp, wx;
    n_mismatch = 0;
    cmp_count = 0;
    seed = 32'h7919e434;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'h1;
    {opt_wdt_always_on, opt_slow_osc_enable, halt_active, opt_fast_source, opt_fast_rc_freq} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk_por();
    chk("reset decode", 32'h8, 32'({ext_int_edge_sel, wdt_enable, dac_enable}));
    wx = 1'b0;
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      v = (i < 4) ? c1[i] : seed[7:0];
      opt_wdt_always_on <= (i < 2) ? i[0] : seed[8];
      wx = ((i < 2) ? i[0] : seed[8]) | (v[3:0] != SCC_WDT_OFF_CODE);
      wr(SCC_ADDR_ITW, v, 4'h1);
      chk_rsp("itw resp", SCC_RESP_OKAY, rsp);
      settle();
      chk("edge", 32'({v[7:6], |v[7:6], v[6], v[7]}),
          32'({ext_int_edge_sel, ext_int_enable, ext_int_rising, ext_int_falling}));
      chk("period", (32'h1 << (10 + v[5:4])) - 32'h1, 32'(timebase_period_m1));
      chk("wdt", 32'(wx), 32'(wdt_enable));
      rd(SCC_ADDR_ITW);
      chk("itw", 32'(v), rd_q);
    end
    // lane 0 strobe off leaves the register alone
    wr(SCC_ADDR_ITW, 8'h00, 4'he);
    rd(SCC_ADDR_ITW);
    chk("itw kept", 32'(v), rd_q);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      v = (i == 0) ? 8'hff : ((i == 1) ? 8'h00 : seed[7:0]);
      wr(SCC_ADDR_DPS, v, 4'h1);
      settle();
      rd(SCC_ADDR_DPS);
      chk("dps", 32'(v & 8'hb1), rd_q);
      chk("dac", 32'(v[7]), 32'(dac_enable));
      chk("pwm pins", 32'(v[5:4]), 32'({pwm3_pin_select, pwm2_pin_select}));
      chk("tb from sys", 32'(v[5] | v[4]), 32'(timer_base_from_sys));
    end
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      h = i[0];
      en = i[1];
      sl = i[2] & en;
      kp = i[3] & en;
      halt_active <= h;
      opt_slow_osc_enable <= en;
      wr(SCC_ADDR_MISC, {6'h0, seed[0], i[2]}, 4'h1);
      wr(SCC_ADDR_DPS, {7'h0, i[3]}, 4'h1);
      settle();
      m = h ? (kp ? 2'd2 : 2'd3) : {1'b0, sl};
      chk("mode", 32'(m), 32'(op_mode));
      chk("clocks", 32'({~h, sl, ~h & ~sl, en & (~h | kp), seed[0]}), 32'({sys_clk_run, sys_clk_from_slow,
          fast_osc_run, slow_osc_run, slow_osc_low_power}));
      rd(SCC_ADDR_STAT);
      chk("status", 32'({wx, ~h, m}), rd_q);
    end
    for (int s = 0; s < 3; s++) begin
      for (int f = 0; f < 4; f++) begin
        opt_fast_source <= s[1:0];
        opt_fast_rc_freq <= f[1:0];
        settle();
        chk("fast", 32'({s[1:0], (f == 3) ? 2'b00 : f[1:0], s != 0, s == 2}), 32'({fast_source,
            fast_rc_freq, port_a_line5_gpio, port_a_line6_gpio}));
      end
    end
    wr(32'h10, 8'h55, 4'h1);
    chk_rsp("unmapped wr", SCC_RESP_SLVERR, rsp);
    rd(32'h10);
    chk_rsp("unmapped rd", SCC_RESP_SLVERR, rsp);
    chk("unmapped data", 32'h0, rd_q);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk_por();
    close_out();
  end
endmodule
